// [rtl/data_signal_mixer.v]
// Data signal mixer: mixes a selected data signal with two selected carriers
// and drives one output pin; registers reached over APB.
// Assumes source inputs are asynchronous to clk_i and glitch-free.
// Assumes an APB master that holds each request until pready is high.
//
// Operation
// - Data high passes the high carrier, data low passes the low carrier.
// - Enable bit starts mixing; clearing it stops output, keeps selections.
// - While disabled the output pin is held low.
// - Five-bit source field picks data from peripherals, software bit or pin.
// - Four-bit high carrier field picks the high carrier source.
// - Four-bit low carrier field picks the low carrier source.
// - With sync on, the active carrier pulse ends before switching carriers.
// - High sync bit governs leaving high carrier, low sync bit leaving low.
// - Each carrier is inverted before mixing when its polarity bit is set.
// - Software data bit drives modulation when selected as source.
// - Output polarity bit inverts the final modulated output.
// - Keeps running in sleep as long as its sources keep running.
// - Any reset disables the block and returns registers to defaults.
// - Power-down clears the block; on re-enable registers hold reset values.
// - Sync bit set means wait for carrier falling edge before switching.
// - Output status bit reads the present module output.
`include "data_signal_mixer_defines.vh"
`timescale 1ns/10ps

module data_signal_mixer #(
    parameter ADDR_W = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    input wire [`DATA_SRC_W-1:0] data_src_i,
    input wire [`CAR_SRC_W-1:0] carrier_high_src_i,
    input wire [`CAR_SRC_W-1:0] carrier_low_src_i,
    input wire mixer_power_down_i,
    output wire mixer_output_pin_o
);

    localparam IN_W = `DATA_SRC_W + 2 * `CAR_SRC_W + 1;

    // ------------------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------------------
    // Every carrier code is mapped, so the mux is a plain index
    function sel_carrier;
        input [`CAR_SRC_W-1:0] data_source_sel;
        input [`CAR_MSB:0] code;
        begin
            sel_carrier = data_source_sel[code];
        end
    endfunction

    // Byte registers sit in the low lane of the 32-bit data bus
    function [31:0] byte_word;
        input [7:0] b;
        begin
            byte_word = {24'h000000, b};
        end
    endfunction

    // Register decode; a misaligned byte address never hits, so it is refused
    function reg_hit;
        input [ADDR_W-1:0] addr;
        input [ADDR_W-3:0] index;
        begin
            reg_hit = (addr[ADDR_W-1:2] == index) && (addr[1:0] == `BYTE_LANE0);
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------------
    // Three stages; a bit changes only once stages two and three agree
    // Limitation: the filter adds about four cycles of delay and drops any
    // level shorter than two cycles, so carriers near clk_i rate do not pass.
    reg [IN_W-1:0] sync1_ff;
    reg [IN_W-1:0] sync2_ff;
    reg [IN_W-1:0] sync3_ff;
    reg [IN_W-1:0] flt_ff;
    wire [IN_W-1:0] raw_in;
    wire [IN_W-1:0] agree;
    wire [IN_W-1:0] nxt_flt;

    assign raw_in = {mixer_power_down_i, carrier_low_src_i, carrier_high_src_i, data_src_i};
    assign agree = ~(sync2_ff ^ sync3_ff);
    assign nxt_flt = (agree & sync3_ff) | (~agree & flt_ff);

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sync1_ff <= {IN_W{1'b0}};
            sync2_ff <= {IN_W{1'b0}};
            sync3_ff <= {IN_W{1'b0}};
            flt_ff <= {IN_W{1'b0}};
        end else begin
            sync1_ff <= raw_in;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            flt_ff <= nxt_flt;
        end
    end

    wire [`DATA_SRC_W-1:0] data_flt;
    wire [`CAR_SRC_W-1:0] carrier_high_sig_flt;
    wire [`CAR_SRC_W-1:0] carrier_low_sig_flt;
    wire pd_flt;

    assign data_flt = flt_ff[`DATA_SRC_W-1:0];
    assign carrier_high_sig_flt = flt_ff[`DATA_SRC_W+`CAR_SRC_W-1:`DATA_SRC_W];
    assign carrier_low_sig_flt = flt_ff[`DATA_SRC_W+2*`CAR_SRC_W-1:`DATA_SRC_W+`CAR_SRC_W];
    assign pd_flt = flt_ff[IN_W-1];

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Control 0 keeps only its writable bits; the status bit is read from out_ff
    reg en_ff;
    reg output_invert_ff;
    reg sw_bit_ff;
    reg [7:0] ctrl1_ff;
    reg [`SRC_MSB:0] data_source_sel_ff;
    reg [`CAR_MSB:0] low_carrier_sel_ff;
    reg [`CAR_MSB:0] high_carrier_sel_ff;
    reg pready_ff;
    reg pslverr_ff;
    reg [31:0] prdata_ff;
    reg out_ff;

    wire hit_c0;
    wire hit_c1;
    wire hit_src;
    wire hit_carrier_low_sig;
    wire hit_carrier_high_sig;
    wire mapped;
    wire wr_en;
    reg [7:0] rd_byte;

    // ------------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------------
    // Only the low byte lane carries data; reserved bits read as zero
    assign hit_c0 = reg_hit(paddr_i, `IDX_CTRL0);
    assign hit_c1 = reg_hit(paddr_i, `IDX_CTRL1);
    assign hit_src = reg_hit(paddr_i, `IDX_SRC);
    assign hit_carrier_low_sig = reg_hit(paddr_i, `IDX_CARRIER_LOW_SIG);
    assign hit_carrier_high_sig = reg_hit(paddr_i, `IDX_CARRIER_HIGH_SIG);
    assign mapped = hit_c0 | hit_c1 | hit_src | hit_carrier_low_sig | hit_carrier_high_sig;
    // Write lands at the access edge that sees pready high
    assign wr_en = psel_i & penable_i & pready_ff & pwrite_i & mapped;

    // ------------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------------
    // Status bit shows the registered pin, one cycle behind the mix
    always @* begin
        rd_byte = `RST_BYTE;
        if (hit_c0) begin
            rd_byte[`C0_EN] = en_ff;
            rd_byte[`C0_OUT] = out_ff;
            rd_byte[`C0_OUTPUT_INVERT] = output_invert_ff;
            rd_byte[`C0_BIT] = sw_bit_ff;
        end else if (hit_c1) begin
            rd_byte = ctrl1_ff;
        end else if (hit_src) begin
            rd_byte[`SRC_MSB:0] = data_source_sel_ff;
        end else if (hit_carrier_low_sig) begin
            rd_byte[`CAR_MSB:0] = low_carrier_sel_ff;
        end else if (hit_carrier_high_sig) begin
            rd_byte[`CAR_MSB:0] = high_carrier_sel_ff;
        end
    end

    // ------------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------------
    // Power-down clears every register each cycle it is asserted; it is seen
    // through the pin filter, so it acts some four cycles after the pin rises.
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            en_ff <= 1'b0;
            output_invert_ff <= 1'b0;
            sw_bit_ff <= 1'b0;
            ctrl1_ff <= `RST_BYTE;
            data_source_sel_ff <= `RST_SRC;
            low_carrier_sel_ff <= `RST_CAR;
            high_carrier_sel_ff <= `RST_CAR;
        end else if (pd_flt) begin
            en_ff <= 1'b0;
            output_invert_ff <= 1'b0;
            sw_bit_ff <= 1'b0;
            ctrl1_ff <= `RST_BYTE;
            data_source_sel_ff <= `RST_SRC;
            low_carrier_sel_ff <= `RST_CAR;
            high_carrier_sel_ff <= `RST_CAR;
        end else if (wr_en) begin
            if (hit_c0) begin
                en_ff <= pwdata_i[`C0_EN];
                output_invert_ff <= pwdata_i[`C0_OUTPUT_INVERT];
                sw_bit_ff <= pwdata_i[`C0_BIT];
            end
            if (hit_c1) begin
                ctrl1_ff <= pwdata_i[7:0] & `C1_MASK;
            end
            if (hit_src) begin
                data_source_sel_ff <= pwdata_i[`SRC_MSB:0];
            end
            if (hit_carrier_low_sig) begin
                low_carrier_sel_ff <= pwdata_i[`CAR_MSB:0];
            end
            if (hit_carrier_high_sig) begin
                high_carrier_sel_ff <= pwdata_i[`CAR_MSB:0];
            end
        end
    end

    // ------------------------------------------------------------------------
    // APB answer
    // ------------------------------------------------------------------------
    // No wait state: answer prepared in setup, pready high in first access
    // pready is registered, so it always trails setup by exactly one edge
    // Unmapped or misaligned access: pslverr with zero read data, write dropped
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h00000000;
        end else begin
            pready_ff <= psel_i & ~penable_i;
            pslverr_ff <= psel_i & ~penable_i & ~mapped;
            if (psel_i & ~penable_i & ~pwrite_i) begin
                prdata_ff <= byte_word(rd_byte);
            end else begin
                prdata_ff <= 32'h00000000;
            end
        end
    end

    assign pready_o = pready_ff;
    assign pslverr_o = pslverr_ff;
    assign prdata_o = prdata_ff;

    // ------------------------------------------------------------------------
    // Source selection and polarity
    // ------------------------------------------------------------------------
    reg data_sig;
    wire car_high_sig;
    wire car_low_sig;

    // Code 1 is the software bit; codes past the top give a quiet low
    always @* begin
        if (data_source_sel_ff == `SRC_SW_BIT) begin
            data_sig = sw_bit_ff;
        end else if (data_source_sel_ff > `SRC_LAST) begin
            data_sig = 1'b0;
        end else begin
            data_sig = data_flt[data_source_sel_ff];
        end
    end

    // Polarity applies before the edge detect, so sync waits for the inverted fall
    assign car_high_sig = sel_carrier(carrier_high_sig_flt, high_carrier_sel_ff) ^ ctrl1_ff[`C1_HIGH_CARRIER_INVERT];
    assign car_low_sig = sel_carrier(carrier_low_sig_flt, low_carrier_sel_ff) ^ ctrl1_ff[`C1_LOW_CARRIER_INVERT];

    // ------------------------------------------------------------------------
    // Carrier switching
    // ------------------------------------------------------------------------
    // Sync delays a carrier change until the active carrier falls, so no
    // pulse is cut short; an idle-low carrier therefore never hands over.
    reg use_high_ff;
    reg car_high_prev_ff;
    reg car_low_prev_ff;
    reg nxt_use_high;
    wire high_fall;
    wire low_fall;
    wire leave_high_ok;
    wire leave_low_ok;

    assign high_fall = car_high_prev_ff & ~car_high_sig;
    assign low_fall = car_low_prev_ff & ~car_low_sig;
    assign leave_high_ok = !ctrl1_ff[`C1_HIGH_CARRIER_SYNC_EN] || high_fall;
    assign leave_low_ok = !ctrl1_ff[`C1_LOW_CARRIER_SYNC_EN] || low_fall;

    // If data returns before the fall, the pending switch is simply dropped
    always @* begin
        nxt_use_high = use_high_ff;
        if (!en_ff) begin
            nxt_use_high = data_sig;
        end else if (data_sig != use_high_ff) begin
            if (use_high_ff) begin
                if (leave_high_ok) begin
                    nxt_use_high = 1'b0;
                end
            end else begin
                if (leave_low_ok) begin
                    nxt_use_high = 1'b1;
                end
            end
        end
    end

    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            use_high_ff <= 1'b0;
            car_high_prev_ff <= 1'b0;
            car_low_prev_ff <= 1'b0;
        end else begin
            use_high_ff <= nxt_use_high;
            car_high_prev_ff <= car_high_sig;
            car_low_prev_ff <= car_low_sig;
        end
    end

    // ------------------------------------------------------------------------
    // Mixing and output
    // ------------------------------------------------------------------------
    // No clock gating here, so sleep only stops it if clk_i itself stops
    // use_high_ff set gives the high carrier as is, with no AND on data; clear takes the low carrier
    wire mix_raw;
    wire nxt_out;

    assign mix_raw = use_high_ff ? car_high_sig : car_low_sig;
    assign nxt_out = en_ff & ~pd_flt & (mix_raw ^ output_invert_ff);

    // Registered pin, so a source change never glitches the output
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            out_ff <= 1'b0;
        end else begin
            out_ff <= nxt_out;
        end
    end

    assign mixer_output_pin_o = out_ff;

endmodule // data_signal_mixer

// [rtl/data_signal_mixer_defines.vh]
// Constants for the data signal mixer: register indices, field positions,
// reset values and selector codes. Definitions only.
`ifndef DATA_SIGNAL_MIXER_DEFINES_VH
`define DATA_SIGNAL_MIXER_DEFINES_VH

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define IDX_CTRL0 14'h0897
`define IDX_CTRL1 14'h0898
`define IDX_SRC 14'h0899
`define IDX_CARRIER_LOW_SIG 14'h089a
`define IDX_CARRIER_HIGH_SIG 14'h089b

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define C0_EN 7
`define C0_OUT 5
`define C0_OUTPUT_INVERT 4
`define C0_BIT 0
`define C1_HIGH_CARRIER_INVERT 5
`define C1_HIGH_CARRIER_SYNC_EN 4
`define C1_LOW_CARRIER_INVERT 1
`define C1_LOW_CARRIER_SYNC_EN 0
`define SRC_MSB 4
`define CAR_MSB 3
`define C1_MASK 8'h33
`define BYTE_LANE0 2'h0

// ----------------------------------------------------------------------------
// Reset values and codes
// ----------------------------------------------------------------------------
`define RST_BYTE 8'h00
`define RST_SRC 5'h00
`define RST_CAR 4'h0
`define SRC_SW_BIT 5'h01
`define SRC_LAST 5'h13
`define DATA_SRC_W 20
`define CAR_SRC_W 16

`endif

// [tb/data_signal_mixer_chk.sv]
// Port checker for the data signal mixer.
// Bound to the top module; sees only its ports.
`timescale 1ns/10ps
`include "data_signal_mixer_defines.vh"
module data_signal_mixer_chk #(
    parameter ADDR_W = 16
) (
    input wire clk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [ADDR_W-1:0] paddr_i,
    input wire [31:0] pwdata_i,
    input wire [31:0] prdata_o,
    input wire pready_o,
    input wire pslverr_o,
    input wire mixer_power_down_i,
    input wire mixer_output_pin_o
);
    logic en_ff;
    logic nxt_en;
    logic rd_ok;
    logic [13:0] idx;
    assign idx = paddr_i[15:2];
    assign rd_ok = pready_o && !pslverr_o && !pwrite_i;
    // Shadow enable; clears at once on power-down, so the idle check allows for the input filter lag
    assign nxt_en = mixer_power_down_i ? 1'b0 : (pready_o && pwrite_i && !pslverr_o && idx == `IDX_CTRL0) ?
        pwdata_i[`C0_EN] : en_ff;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            en_ff <= 1'b0;
        else
            en_ff <= nxt_en;
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    ready_setup_a: assert property (psel_i && !penable_i |=> pready_o)
        else $error("no ready in first access cycle");
    ready_access_a: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access cycle");
    upper_zero_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
        else $error("upper read data not zero");
    err_zero_a: assert property (pslverr_o |-> pready_o && prdata_o == 32'h00000000)
        else $error("error response malformed");
    idle_low_a: assert property (!en_ff [*6] |-> !mixer_output_pin_o)
        else $error("output high while disabled");
    reset_low_a: assert property ($rose(rst_n_i) |-> !mixer_output_pin_o && !pready_o)
        else $error("outputs active after reset");
    status_bit_a: assert property (rd_ok && idx == `IDX_CTRL0 && $stable(mixer_output_pin_o) &&
        $past(mixer_output_pin_o, 2) == mixer_output_pin_o |-> prdata_o[`C0_OUT] == mixer_output_pin_o)
        else $error("status bit differs from output");
    src_field_a: assert property (rd_ok && idx == `IDX_SRC |-> prdata_o[7:5] == 3'h0)
        else $error("source register too wide");
    car_field_a: assert property (rd_ok && (idx == `IDX_CARRIER_LOW_SIG || idx == `IDX_CARRIER_HIGH_SIG) |-> prdata_o[7:4] == 4'h0)
        else $error("carrier register too wide");
    cover property (pready_o && pwrite_i);
    cover property (pslverr_o);
    cover property ($rose(mixer_output_pin_o));
endmodule // data_signal_mixer_chk
bind data_signal_mixer data_signal_mixer_chk #(.ADDR_W(ADDR_W)) data_signal_mixer_chk_i (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .mixer_power_down_i(mixer_power_down_i), .mixer_output_pin_o(mixer_output_pin_o));

// [tb/data_signal_mixer_tb.sv]
// Self-checking bench for the data signal mixer.
// Drives APB and the source model; output settles within 8 cycles.
`timescale 1ns/10ps
`include "data_signal_mixer_defines.vh"
module data_signal_mixer_tb;
    logic clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pd = 1'b0;
    logic data_lvl = 1'b0, hi_run = 1'b0, lo_lvl = 1'b0;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h00000000;
    logic [4:0] pick = 5'h00;
    wire [31:0] prdata;
    wire pready, pslverr, out;
    wire [19:0] dsrc;
    wire [15:0] hsrc, lsrc;
    int failures = 0;
    int samples_checked = 0;
    always #25 clk_i = ~clk_i;
    data_signal_mixer #(.ADDR_W(16)) data_signal_mixer_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .data_src_i(dsrc), .carrier_high_src_i(hsrc),
        .carrier_low_src_i(lsrc), .mixer_power_down_i(pd), .mixer_output_pin_o(out));
    signal_source_model signal_source_model_i (.clk_i(clk_i), .rst_n_i(rst_n_i), .pick_i(pick),
        .data_lvl_i(data_lvl), .hi_run_i(hi_run), .lo_lvl_i(lo_lvl), .data_src_o(dsrc),
        .carrier_high_src_o(hsrc), .carrier_low_src_o(lsrc));
    task chk(input logic [31:0] s, input logic [31:0] x);
        samples_checked++;
        if (s !== x) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [13:0] i, input logic [7:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {i, 2'b00};
        pwdata <= {24'h000000, d};
        @(posedge clk_i);
        penable <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1)
            failures++;
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [13:0] i, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, i, d, r, e);
    endtask
    task automatic rd(input logic [13:0] i, input logic [31:0] x);
        logic [31:0] r;
        logic e;
        apb(1'b0, i, 8'h00, r, e);
        chk(r, x);
    endtask
    task settle(input logic x);
        repeat (8) @(negedge clk_i);
        chk(out, x);
        @(posedge clk_i);
    endtask
    task automatic t_regs;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 5; i++) begin
            rd(14'(`IDX_CTRL0 + i), 32'h0);
        end
        for (int i = 1; i < 5; i++) begin
            wr(14'(`IDX_CTRL0 + i), 8'hff);
            rd(14'(`IDX_CTRL0 + i), i == 1 ? 32'h33 : i == 2 ? 32'h1f : 32'h0f);
            wr(14'(`IDX_CTRL0 + i), 8'h00);
        end
        wr(`IDX_CTRL0, 8'h5f);
        rd(`IDX_CTRL0, 32'h11);
        settle(1'b0);
        wr(`IDX_CTRL0, 8'h00);
        apb(1'b0, 14'h089c, 8'h00, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        $display("register test done");
    endtask
    task t_mix;
        for (int c = 0; c < 22; c++) begin
            pick <= 5'(c);
            data_lvl <= 1'b1;
            lo_lvl <= 1'b0;
            wr(`IDX_SRC, 8'(c));
            wr(`IDX_CARRIER_HIGH_SIG, 8'(c % 16));
            wr(`IDX_CARRIER_LOW_SIG, 8'(c % 16));
            wr(`IDX_CTRL0, c == 1 ? 8'h81 : 8'h80);
            settle(c < 20);
            data_lvl <= 1'b0;
            lo_lvl <= 1'b1;
            wr(`IDX_CTRL0, 8'h80);
            settle(1'b1);
        end
        $display("mixing test done");
    endtask
    task t_pol;
        pick <= 5'h02;
        data_lvl <= 1'b1;
        lo_lvl <= 1'b0;
        wr(`IDX_SRC, 8'h02);
        wr(`IDX_CARRIER_HIGH_SIG, 8'h02);
        wr(`IDX_CARRIER_LOW_SIG, 8'h02);
        wr(`IDX_CTRL1, 8'h20);
        wr(`IDX_CTRL0, 8'h80);
        settle(1'b0);
        data_lvl <= 1'b0;
        wr(`IDX_CTRL1, 8'h22);
        settle(1'b1);
        wr(`IDX_CTRL0, 8'h90);
        settle(1'b0);
        wr(`IDX_CTRL0, 8'h10);
        settle(1'b0);
        rd(`IDX_SRC, 32'h02);
        wr(`IDX_CTRL0, 8'h80);
        settle(1'b1);
        rd(`IDX_CTRL0, 32'ha0);
        wr(`IDX_CTRL1, 8'h00);
        $display("polarity test done");
    endtask
    // A late software bit drop while the high carrier is up: only high sync keeps the pulse whole
    task automatic t_sync(input logic [7:0] c1, input logic lng);
        int n;
        pick <= 5'h00;
        hi_run <= 1'b1;
        lo_lvl <= 1'b0;
        wr(`IDX_SRC, 8'h01);
        wr(`IDX_CARRIER_HIGH_SIG, 8'h00);
        wr(`IDX_CARRIER_LOW_SIG, 8'h00);
        wr(`IDX_CTRL1, c1);
        // Disabled, the switch follows data, so mixing starts on the high carrier
        wr(`IDX_CTRL0, 8'h01);
        wr(`IDX_CTRL0, 8'h81);
        n = 0;
        while (out !== 1'b0 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        while (out !== 1'b1 && n < 80) begin
            @(negedge clk_i);
            n++;
        end
        chk(out, 1'b1);
        wr(`IDX_CTRL0, 8'h80);
        n = 0;
        while (out === 1'b1 && n < 40) begin
            @(negedge clk_i);
            n++;
        end
        chk(n > 8, lng);
        $display("sync test done");
        @(posedge clk_i);
    endtask
    task t_pdown;
        hi_run <= 1'b0;
        wr(`IDX_CTRL0, 8'h01);
        wr(`IDX_CTRL0, 8'h81);
        settle(1'b1);
        pd <= 1'b1;
        repeat (10) @(posedge clk_i);
        pd <= 1'b0;
        settle(1'b0);
        rd(`IDX_CTRL0, 32'h0);
        rd(`IDX_SRC, 32'h0);
        rd(`IDX_CTRL1, 32'h0);
        $display("power-down test done");
    endtask
    initial begin
        repeat (8) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_regs;
        t_mix;
        t_pol;
        t_sync(8'h10, 1'b1);
        t_sync(8'h00, 1'b0);
        t_sync(8'h01, 1'b0);
        t_pdown;
        wrap_up;
    end
    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        wrap_up;
    end
endmodule // data_signal_mixer_tb

// [tb/signal_source_model.sv]
// Model of the peripherals feeding the mixer.
// Only the line at pick_i is active; the rest sit low like idle peripherals.
`timescale 1ns/10ps
module signal_source_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [4:0] pick_i,
    input wire logic data_lvl_i,
    input wire logic hi_run_i,
    input wire logic lo_lvl_i,
    output logic [19:0] data_src_o,
    output logic [15:0] carrier_high_src_o,
    output logic [15:0] carrier_low_src_o
);
    logic [4:0] cnt_ff;
    always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i)
            cnt_ff <= 5'h00;
        else
            cnt_ff <= cnt_ff + 5'h01;
    end
    // Data codes past the top fall off the shift and see a silent source; carriers wrap on pick_i[3:0]
    assign data_src_o = {19'h00000, data_lvl_i} << pick_i;
    assign carrier_high_src_o = {15'h0000, hi_run_i ? cnt_ff[4] : 1'b1} << pick_i[3:0];
    assign carrier_low_src_o = {15'h0000, lo_lvl_i} << pick_i[3:0];
endmodule // signal_source_model
